// *** include/dac_pkg.sv ***
package dac_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int COUNT_W = 16;
  localparam int BEAT_W  = 2;
  localparam int STEP_W  = 3;

  // Register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SRC       = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DST       = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DESC_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_WB_BASE   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_NEXT_DESC = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CMD       = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SRC_CUR   = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_DST_CUR   = 8'h28;

  // block_transfer_control fields
  localparam int CTRL_SRC_INC  = 0;
  localparam int CTRL_DST_INC  = 1;
  localparam int CTRL_STEP_SEL = 2;
  localparam int CTRL_STEP_LSB = 4;
  localparam int CTRL_BEAT_LSB = 8;
  localparam int CTRL_USED_W   = 10;

  // Command and status bits
  localparam int CMD_START   = 0;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_DONE = 1;

  // Descriptor pointers must sit on a 64-bit boundary
  localparam int ALIGN_BITS = 3;

  localparam logic [CTRL_USED_W-1:0] CTRL_RESET  = 10'h000;
  localparam logic [COUNT_W-1:0]     COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0]      ADDR_RESET  = 32'h0000_0000;

  typedef enum logic [1:0] {
    DAC_IDLE = 2'b00,
    DAC_LOAD = 2'b01,
    DAC_RUN  = 2'b10
  } dac_state_t;

endpackage

// *** hw/dac_span_calc.sv ***
`timescale 1ns/1ps
module dac_span_calc (
  input  wire logic [dac_pkg::COUNT_W-1:0] count,
  input  wire logic [dac_pkg::BEAT_W-1:0]  beat_size,
  input  wire logic [dac_pkg::STEP_W-1:0]  step_exp,
  input  wire logic                        apply_step,
  output logic      [dac_pkg::DATA_W-1:0]  span,
  output logic      [dac_pkg::DATA_W-1:0]  step
);

  logic [dac_pkg::DATA_W-1:0] beat_bytes;
  logic [dac_pkg::DATA_W-1:0] base;
  logic [dac_pkg::STEP_W-1:0] shift;

  always_comb begin
    beat_bytes = {30'h0000_0000, beat_size} + 32'h0000_0001;
    base       = 32'({16'h0000, count} * beat_bytes);
    shift      = apply_step ? step_exp : 3'h0;
    // Shifter instead of a multiplier: the factor is always a power of two
    span       = base << shift;
    step       = beat_bytes << shift;
  end

endmodule

// *** hw/dac_addr_channel.sv ***
`timescale 1ns/1ps
module dac_addr_channel (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       load,
  input  wire logic                       advance,
  input  wire logic                       inc_en,
  input  wire logic [dac_pkg::DATA_W-1:0] field,
  input  wire logic [dac_pkg::DATA_W-1:0] span,
  input  wire logic [dac_pkg::DATA_W-1:0] step,
  output logic      [dac_pkg::DATA_W-1:0] cur
);

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= dac_pkg::ADDR_RESET;
    end else if (load) begin
      // Stored field is the end address when incrementing, the fixed address otherwise
      cur <= inc_en ? field - span : field;
    end else if (advance && inc_en) begin
      cur <= cur + step;
    end
  end

endmodule

// *** hw/dac_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Source address field holds the block's source address, 32 bits.
// - Source increment off: source field is the address of every beat.
// - Source increment on: field = start + count*(size+1), shifted if step select 1.
// - Destination address field holds the block's destination address, 32 bits.
// - Destination increment off: destination field is the address of every beat.
// - Destination increment on: same formula, shifted only when step select 0.
// - Start term is first beat address; count term is initial beats remaining.
// - Size term is bytes per beat minus one; step term is log2 of beats per increment.
module dac_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [dac_pkg::ADDR_W-1:0]  addr,
  input  wire logic [dac_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [dac_pkg::DATA_W-1:0]  rd_data,
  output logic                             beat_valid,
  output logic      [dac_pkg::DATA_W-1:0]  beat_source_address,
  output logic      [dac_pkg::DATA_W-1:0]  beat_destination_address,
  output logic                             busy,
  output logic                             done
);

  logic [dac_pkg::CTRL_USED_W-1:0] block_transfer_control;
  logic [dac_pkg::COUNT_W-1:0]     beat_count;
  logic [dac_pkg::DATA_W-1:0]      transfer_source_address;
  logic [dac_pkg::DATA_W-1:0]      transfer_destination_address;
  logic [dac_pkg::DATA_W-1:0]      descriptor_base_address;
  logic [dac_pkg::DATA_W-1:0]      writeback_base_address;
  logic [dac_pkg::DATA_W-1:0]      next_descriptor_address;
  logic [dac_pkg::COUNT_W-1:0]     remaining;
  dac_pkg::dac_state_t             state;
  dac_pkg::dac_state_t             next_state;

  logic                        source_increment_enable;
  logic                        destination_increment_enable;
  logic                        step_target_select;
  logic [dac_pkg::STEP_W-1:0]  step_size_exponent;
  logic [dac_pkg::BEAT_W-1:0]  beat_size_a;
  logic                        cfg_write;
  logic                        start_req;
  logic                        load;
  logic                        advance;
  logic [dac_pkg::DATA_W-1:0]  src_span;
  logic [dac_pkg::DATA_W-1:0]  src_step;
  logic [dac_pkg::DATA_W-1:0]  dst_span;
  logic [dac_pkg::DATA_W-1:0]  dst_step;
  logic [dac_pkg::DATA_W-1:0]  src_cur;
  logic [dac_pkg::DATA_W-1:0]  dst_cur;

  function automatic logic [dac_pkg::DATA_W-1:0] align64(input logic [dac_pkg::DATA_W-1:0] v);
    align64 = {v[dac_pkg::DATA_W-1:dac_pkg::ALIGN_BITS], 3'h0};
  endfunction

  assign source_increment_enable      = block_transfer_control[dac_pkg::CTRL_SRC_INC];
  assign destination_increment_enable = block_transfer_control[dac_pkg::CTRL_DST_INC];
  assign step_target_select           = block_transfer_control[dac_pkg::CTRL_STEP_SEL];
  assign step_size_exponent =
    block_transfer_control[dac_pkg::CTRL_STEP_LSB +: dac_pkg::STEP_W];
  assign beat_size_a = block_transfer_control[dac_pkg::CTRL_BEAT_LSB +: dac_pkg::BEAT_W];

  // Configuration is frozen while a block is walked so spans stay consistent
  assign cfg_write = wr_en && !busy;
  assign start_req = cfg_write && (addr == dac_pkg::OFF_CMD) && wr_data[dac_pkg::CMD_START];
  assign load      = (state == dac_pkg::DAC_LOAD);
  assign advance   = (state == dac_pkg::DAC_RUN) && (remaining != 16'h0000);

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      block_transfer_control <= dac_pkg::CTRL_RESET;
      beat_count             <= dac_pkg::COUNT_RESET;
    end else if (cfg_write) begin
      if (addr == dac_pkg::OFF_CTRL) begin
        block_transfer_control <= wr_data[dac_pkg::CTRL_USED_W-1:0];
      end
      if (addr == dac_pkg::OFF_COUNT) begin
        beat_count <= wr_data[dac_pkg::COUNT_W-1:0];
      end
    end
  end

  // Address fields
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_source_address      <= dac_pkg::ADDR_RESET;
      transfer_destination_address <= dac_pkg::ADDR_RESET;
    end else if (cfg_write) begin
      if (addr == dac_pkg::OFF_SRC) begin
        transfer_source_address <= wr_data;
      end
      if (addr == dac_pkg::OFF_DST) begin
        transfer_destination_address <= wr_data;
      end
    end
  end

  // Descriptor pointers: low bits dropped, software keeps them aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      descriptor_base_address <= dac_pkg::ADDR_RESET;
      writeback_base_address  <= dac_pkg::ADDR_RESET;
      next_descriptor_address <= dac_pkg::ADDR_RESET;
    end else if (cfg_write) begin
      if (addr == dac_pkg::OFF_DESC_BASE) begin
        descriptor_base_address <= align64(wr_data);
      end
      if (addr == dac_pkg::OFF_WB_BASE) begin
        writeback_base_address <= align64(wr_data);
      end
      if (addr == dac_pkg::OFF_NEXT_DESC) begin
        next_descriptor_address <= align64(wr_data);
      end
    end
  end

  // Source multiplies by the step only when step select is 1
  dac_span_calc u_src_span (
    .count      (beat_count),
    .beat_size  (beat_size_a),
    .step_exp   (step_size_exponent),
    .apply_step (step_target_select),
    .span       (src_span),
    .step       (src_step)
  );

  // Destination multiplies by the step only when step select is 0
  dac_span_calc u_dst_span (
    .count      (beat_count),
    .beat_size  (beat_size_a),
    .step_exp   (step_size_exponent),
    .apply_step (!step_target_select),
    .span       (dst_span),
    .step       (dst_step)
  );

  dac_addr_channel u_src_chan (
    .clk     (clk),
    .rst     (rst),
    .load    (load),
    .advance (advance),
    .inc_en  (source_increment_enable),
    .field   (transfer_source_address),
    .span    (src_span),
    .step    (src_step),
    .cur     (src_cur)
  );

  dac_addr_channel u_dst_chan (
    .clk     (clk),
    .rst     (rst),
    .load    (load),
    .advance (advance),
    .inc_en  (destination_increment_enable),
    .field   (transfer_destination_address),
    .span    (dst_span),
    .step    (dst_step),
    .cur     (dst_cur)
  );

  // Walk sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      dac_pkg::DAC_IDLE: begin
        if (start_req) begin
          next_state = dac_pkg::DAC_LOAD;
        end
      end
      dac_pkg::DAC_LOAD: begin
        next_state = dac_pkg::DAC_RUN;
      end
      dac_pkg::DAC_RUN: begin
        if (remaining == 16'h0000) begin
          next_state = dac_pkg::DAC_IDLE;
        end
      end
      default: begin
        next_state = dac_pkg::DAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= dac_pkg::DAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Beats left, seeded from the initial count
  always_ff @(posedge clk) begin
    if (rst) begin
      remaining <= dac_pkg::COUNT_RESET;
    end else if (start_req) begin
      remaining <= beat_count;
    end else if (advance) begin
      remaining <= remaining - 16'h0001;
    end
  end

  // Beat stream
  always_ff @(posedge clk) begin
    if (rst) begin
      beat_valid               <= 1'b0;
      beat_source_address      <= dac_pkg::ADDR_RESET;
      beat_destination_address <= dac_pkg::ADDR_RESET;
    end else begin
      beat_valid <= advance;
      if (advance) begin
        beat_source_address      <= src_cur;
        beat_destination_address <= dst_cur;
      end
    end
  end

  // Status
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start_req) begin
      busy <= 1'b1;
      done <= 1'b0;
    end else if (state == dac_pkg::DAC_RUN && remaining == 16'h0000) begin
      busy <= 1'b0;
      done <= 1'b1;
    end
  end

  // Read port, data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr)
        dac_pkg::OFF_CTRL:      rd_data <= {22'h00_0000, block_transfer_control};
        dac_pkg::OFF_COUNT:     rd_data <= {16'h0000, beat_count};
        dac_pkg::OFF_SRC:       rd_data <= transfer_source_address;
        dac_pkg::OFF_DST:       rd_data <= transfer_destination_address;
        dac_pkg::OFF_DESC_BASE: rd_data <= descriptor_base_address;
        dac_pkg::OFF_WB_BASE:   rd_data <= writeback_base_address;
        dac_pkg::OFF_NEXT_DESC: rd_data <= next_descriptor_address;
        dac_pkg::OFF_STATUS:    rd_data <= {30'h0000_0000, done, busy};
        dac_pkg::OFF_SRC_CUR:   rd_data <= src_cur;
        dac_pkg::OFF_DST_CUR:   rd_data <= dst_cur;
        default:                rd_data <= 32'h0000_0000;
      endcase
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // Helper state for the checks below
  logic                    first_beat;
  logic [dac_pkg::COUNT_W:0] beats_seen;

  always_ff @(posedge clk) begin
    if (rst) begin
      first_beat <= 1'b0;
    end else begin
      first_beat <= load;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      beats_seen <= 17'h0_0000;
    end else if (start_req) begin
      beats_seen <= 17'h0_0000;
    end else if (beat_valid) begin
      beats_seen <= beats_seen + 17'h0_0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_src_field_write: assert property (
    wr_en && !busy && addr == dac_pkg::OFF_SRC |=> transfer_source_address == $past(wr_data))
    else $error("source field not stored");

  a_dst_field_write: assert property (
    wr_en && !busy && addr == dac_pkg::OFF_DST |=> transfer_destination_address == $past(wr_data))
    else $error("destination field not stored");

  a_src_fixed_addr: assert property (
    beat_valid && !source_increment_enable |-> beat_source_address == transfer_source_address)
    else $error("fixed source beat off its field");

  a_dst_fixed_addr: assert property (
    beat_valid && !destination_increment_enable
      |-> beat_destination_address == transfer_destination_address)
    else $error("fixed destination beat off its field");

  a_src_end_formula: assert property (
    beat_valid && first_beat == 1'b0 && $past(first_beat) && source_increment_enable
      |-> beat_source_address + src_span == transfer_source_address)
    else $error("source field not start plus span");

  a_dst_end_formula: assert property (
    beat_valid && $past(first_beat) && destination_increment_enable
      |-> beat_destination_address + dst_span == transfer_destination_address)
    else $error("destination field not start plus span");

  a_beat_total: assert property (
    $rose(done) |-> beats_seen == {1'b0, beat_count})
    else $error("beat total differs from initial count");

  a_src_step_size: assert property (
    beat_valid && $past(beat_valid) && source_increment_enable
      |-> beat_source_address - $past(beat_source_address) == src_step)
    else $error("source step wrong");

  a_start_to_beat: assert property (
    start_req && beat_count != 16'h0000 |-> ##3 beat_valid)
    else $error("first beat late");

  c_both_inc: cover property (
    beat_valid && source_increment_enable && destination_increment_enable);
  c_zero_count: cover property (start_req && beat_count == 16'h0000 ##3 $rose(done));
  c_src_stepped: cover property (beat_valid && step_target_select && step_size_exponent != 3'h0);

endmodule

// *** testbench/dac_bus_watch.sv ***
`timescale 1ns/1ps
module dac_bus_watch (
  input wire logic                       clk,
  input wire logic                       beat_valid,
  input wire logic [dac_pkg::DATA_W-1:0] src_addr,
  input wire logic [dac_pkg::DATA_W-1:0] dst_addr
);
  logic [dac_pkg::DATA_W-1:0] src_seen[$];
  logic [dac_pkg::DATA_W-1:0] dst_seen[$];

  // Bus side only records beats; it never stalls the walk
  always @(posedge clk) begin
    if (beat_valid === 1'b1) begin
      src_seen.push_back(src_addr);
      dst_seen.push_back(dst_addr);
    end
  end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic                         clk     = 1'b0;
  logic                         rst     = 1'b1;
  logic [dac_pkg::ADDR_W-1:0]   addr    = 8'h00;
  logic [dac_pkg::DATA_W-1:0]   wr_data = 32'h0000_0000;
  logic                         wr_en   = 1'b0;
  logic                         rd_en   = 1'b0;
  logic [dac_pkg::DATA_W-1:0]   rd_data;
  logic                         beat_valid;
  logic [dac_pkg::DATA_W-1:0]   bsa;
  logic [dac_pkg::DATA_W-1:0]   bda;
  logic                         busy;
  logic                         done;
  int                           fails = 0;
  int                           comparisons = 0;

  always #12.5 clk = ~clk;

  dac_top dac_top_i (
    .clk                      (clk),
    .rst                      (rst),
    .addr                     (addr),
    .wr_data                  (wr_data),
    .wr_en                    (wr_en),
    .rd_en                    (rd_en),
    .rd_data                  (rd_data),
    .beat_valid               (beat_valid),
    .beat_source_address      (bsa),
    .beat_destination_address (bda),
    .busy                     (busy),
    .done                     (done)
  );

  dac_bus_watch dac_bus_watch_i (
    .clk        (clk),
    .beat_valid (beat_valid),
    .src_addr   (bsa),
    .dst_addr   (bda)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rd_data, exp, "read data");
  endtask

  // Expected beat address, worked out independently of the design
  function automatic logic [31:0] beat_at(logic [31:0] field, logic inc, logic app,
                                          logic [2:0] ex, logic [1:0] bs,
                                          logic [15:0] n, int k);
    logic [31:0] st;
    st = ({30'h0, bs} + 32'h1) << (app ? ex : 3'h0);
    if (!inc) return field;
    return field - 32'(n) * st + 32'(k) * st;
  endfunction

  task automatic test_regs();
    logic [7:0] ptr [3];
    ptr = '{dac_pkg::OFF_DESC_BASE, dac_pkg::OFF_WB_BASE, dac_pkg::OFF_NEXT_DESC};
    for (int a = 0; a <= 8'h28; a += 4) begin
      rd(8'(a), 32'h0000_0000);
    end
    wr(dac_pkg::OFF_SRC, 32'hffff_ffff);
    rd(dac_pkg::OFF_SRC, 32'hffff_ffff);
    wr(dac_pkg::OFF_DST, 32'ha5a5_5a5b);
    rd(dac_pkg::OFF_DST, 32'ha5a5_5a5b);
    foreach (ptr[i]) begin
      // 64-bit aligned but deliberately not 128-bit aligned
      wr(ptr[i], 32'hfedc_ba98);
      rd(ptr[i], 32'hfedc_ba98);
    end
    wr(dac_pkg::OFF_STATUS, 32'hffff_ffff);
    rd(dac_pkg::OFF_STATUS, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    rd(dac_pkg::OFF_CMD, 32'h0000_0000);
  endtask

  // Poke adds a rewrite and a restart while the walk is running
  task automatic walk(input logic si, input logic di, input logic sel, input logic [2:0] ex,
                      input logic [1:0] bs, input logic [15:0] n, input logic [31:0] s,
                      input logic [31:0] d, input logic poke);
    int w;
    wr(dac_pkg::OFF_CTRL, {22'h0, bs, 1'b0, ex, 1'b0, sel, di, si});
    wr(dac_pkg::OFF_COUNT, {16'h0, n});
    wr(dac_pkg::OFF_SRC, s);
    wr(dac_pkg::OFF_DST, d);
    dac_bus_watch_i.src_seen.delete();
    dac_bus_watch_i.dst_seen.delete();
    wr(dac_pkg::OFF_CMD, 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, busy}, 32'h1, "busy after start");
    if (poke) begin
      wr(dac_pkg::OFF_SRC, ~s);
      wr(dac_pkg::OFF_CMD, 32'h0000_0001);
    end
    w = 0;
    while (busy !== 1'b0 && w < n + 10) begin
      @(negedge clk);
      w++;
    end
    chk({31'h0, busy}, 32'h0, "busy after walk");
    chk({31'h0, done}, 32'h1, "done after walk");
    chk(32'(dac_bus_watch_i.src_seen.size()), 32'(n), "beat count");
    foreach (dac_bus_watch_i.src_seen[k]) begin
      chk(dac_bus_watch_i.src_seen[k], beat_at(s, si, sel, ex, bs, n, k), "src");
      chk(dac_bus_watch_i.dst_seen[k], beat_at(d, di, !sel, ex, bs, n, k), "dst");
    end
    // A finished walk leaves each pointer on its stored field
    rd(dac_pkg::OFF_SRC_CUR, s);
    rd(dac_pkg::OFF_DST_CUR, d);
    if (poke) begin
      rd(dac_pkg::OFF_SRC, s);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    walk(1'b1, 1'b0, 1'b1, 3'h3, 2'h2, 16'd4, 32'h2000_0100, 32'h3000_0040, 1'b0);
    walk(1'b1, 1'b1, 1'b0, 3'h7, 2'h3, 16'd3, 32'h0000_1000, 32'h4000_2000, 1'b0);
    walk(1'b0, 1'b0, 1'b1, 3'h5, 2'h0, 16'd2, 32'h0000_0123, 32'h0000_0456, 1'b0);
    walk(1'b1, 1'b1, 1'b1, 3'h1, 2'h1, 16'd0, 32'h0000_0010, 32'h0000_0020, 1'b0);
    walk(1'b1, 1'b1, 1'b1, 3'h0, 2'h0, 16'd1, 32'h0000_0000, 32'h0000_0001, 1'b0);
    walk(1'b1, 1'b1, 1'b0, 3'h2, 2'h1, 16'd6, 32'h0000_8000, 32'h0001_0000, 1'b1);
    test_done();
  end

  // Whole run is a few hundred cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
